// *** logic/ftpu_defines.vh ***
// Constants of the five-channel timer pulse unit: APB offsets, field positions and reset values.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef FTPU_DEFINES_VH
`define FTPU_DEFINES_VH

// ==========================================================================
// Shared registers
`define FTPU_OFF_START   8'h00
`define FTPU_OFF_SYNC    8'h04
`define FTPU_OFF_MODE    8'h08
`define FTPU_OFF_STATUS  8'h0C
`define FTPU_OFF_IEN     8'h10

// ==========================================================================
// Channel windows: channel n at (FTPU_CH_FIRST + n) * 0x20, selected by paddr[7:5]
`define FTPU_CH_FIRST    3'h2
`define FTPU_CH_LAST     3'h6
`define FTPU_SUB_CTRL    3'h0
`define FTPU_SUB_IOCTL   3'h1
`define FTPU_SUB_CNT     3'h2
`define FTPU_SUB_GRA     3'h3
`define FTPU_SUB_GRB     3'h4
`define FTPU_SUB_BRA     3'h5
`define FTPU_SUB_BRB     3'h6

// ==========================================================================
// Mode register fields
`define FTPU_MODE_PHASE  5
`define FTPU_MODE_RSPWM  6
`define FTPU_MODE_CPWM   7
`define FTPU_MODE_BUF3   8
`define FTPU_MODE_BUF4   9

// Channel control: clock select [2:0], clear select [4:3]
`define FTPU_CLR_NONE    2'h0
`define FTPU_CLR_A       2'h1
`define FTPU_CLR_B       2'h2
`define FTPU_CLR_SYNC    2'h3

// Reset values and counter maximum
`define FTPU_GR_RESET    16'hFFFF
`define FTPU_CNT_RESET   16'h0000
`define FTPU_CNT_MAX     16'hFFFF

`endif

// *** logic/ftpu_timer_pulse_unit.v ***
// Five-channel 16-bit timer pulse unit with an APB register slave.
// Assumes pins and APB are synchronous to pclk; pin levels are resolved outside from the enables.
//
// Behaviour
// [RL1] Five independent channels, each with a 16-bit up-counter.
// [RL2] Per-channel clock: pclk divided by 1, 2, 4, 8 or one of four external clocks.
// [RL3] Two general registers per channel, each compare or capture independently.
// [RL4] Compare match drives pin 0, 1 or toggles; channel 2 has no toggle.
// [RL5] Capture latches the counter on rising, falling or both pin edges.
// [RL6] Counter clears to zero on compare or capture of register A or B.
// [RL7] In sync mode one counter write loads all synchronized counters together.
// [RL8] In sync mode a clear in one synchronized channel clears all of them that select sync clear.
// [RL9] PWM mode gives any duty per channel; with sync up to five phases.
// [RL10] Channel 2 phase counting mode counts up or down from a quadrature pair.
// [RL11] Channels 3 and 4 give reset-synchronized three-phase PWM, positive and negative.
// [RL12] Channels 3 and 4 give complementary three-phase PWM that never overlaps.
// [RL13] Channels 3 and 4 have buffer registers for capture and compare transfer.
// [RL14] Counter, general and buffer registers are full 16-bit registers on the bus.
// [RL15] Fifteen separate interrupt requests: A, B and overflow per channel.
// [RL16] Register A events of channels 0 to 3 request DMA; channel 4 does not.
// [RL17] Compare and capture events of channels 0 to 3 go out as pattern triggers.
// [RL18] At most twelve pulse outputs and ten pulse inputs in total.
// [RL19] In phase counting, external clocks A and B are the two encoder phases.
// [RL20] Channel 4 has two extra output pins, used only in three-phase PWM modes.
// [RL21] Counter wrap sets the overflow flag and requests its interrupt if enabled.
// [RL22] Clock and capture inputs are synchronized before edges count once each.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "ftpu_defines.vh"

module ftpu_timer_pulse_unit #(
  parameter NCH = 5
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_clock_in_a,
  input  wire        ext_clock_in_b,
  input  wire        ext_clock_in_c,
  input  wire        ext_clock_in_d,
  input  wire [4:0]  capture_compare_pin_a_in,
  input  wire [4:0]  capture_compare_pin_b_in,
  output reg  [4:0]  capture_compare_pin_a_out,
  output reg  [4:0]  capture_compare_pin_a_oe,
  output reg  [4:0]  capture_compare_pin_b_out,
  output reg  [4:0]  capture_compare_pin_b_oe,
  output reg         extra_pwm_out_a_ch4,
  output reg         extra_pwm_out_b_ch4,
  output reg  [14:0] irq,
  output reg  [3:0]  dma_req,
  output reg  [3:0]  tpc_trig
);

  // ==========================================================================
  // Helpers
  function cap_hit;
    input [2:0] io;
    input       r;
    input       f;
    begin
      cap_hit = io[2] & (io[1] ? (r | f) : (io[0] ? f : r)); // [RL5]
    end
  endfunction

  function pin_next;
    input [2:0] io;
    input       cur;
    input       tog_ok;
    begin
      case (io[1:0])
        2'h1:    pin_next = 1'b0;
        2'h2:    pin_next = 1'b1;
        2'h3:    pin_next = tog_ok ? ~cur : 1'b1; // [RL4]
        default: pin_next = cur;
      endcase
    end
  endfunction

  // ==========================================================================
  // APB decode; zero wait states, answer registered during setup
  wire       setup   = psel & ~penable;
  // A refused address answers with pslverr and must not touch any register.
  wire       wr      = psel & penable & pwrite & pready & ~pslverr;
  wire [2:0] chsel   = paddr[7:5];
  wire [2:0] sub     = paddr[4:2];
  wire       in_ch   = (chsel >= `FTPU_CH_FIRST) && (chsel <= `FTPU_CH_LAST);
  wire [2:0] chidx   = chsel - `FTPU_CH_FIRST;
  wire       wr_com  = wr && (chsel == 3'h0);

  reg  [4:0] start;
  reg  [4:0] sync;
  reg  [9:0] mode;
  reg [14:0] ien;

  wire [79:0] cnt_f;
  wire [79:0] gra_f;
  wire [79:0] grb_f;
  wire [79:0] bra_f;
  wire [79:0] brb_f;
  wire [24:0] ctl_f;
  wire [29:0] io_f;
  wire [14:0] flags;
  wire  [4:0] clr_req;
  wire  [4:0] pin_a;
  wire  [4:0] pin_b;
  wire  [4:0] oe_a;
  wire  [4:0] oe_b;
  wire  [4:0] ev_a;
  wire  [4:0] ev_b;

  wire [4:0] cnt_wr_ch;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_dec
      assign cnt_wr_ch[g] = wr && in_ch && (chidx == g) && (sub == `FTPU_SUB_CNT);
    end
  endgenerate

  wire sync_load = |(cnt_wr_ch & sync); // [RL7]
  wire sync_clr  = |(clr_req & sync);   // [RL8]
  wire rspwm     = mode[`FTPU_MODE_RSPWM];
  wire cpwm      = mode[`FTPU_MODE_CPWM];

  // ==========================================================================
  // Input synchronizers and prescaler
  reg [13:0] s1;
  reg [13:0] s2;
  reg [13:0] s3;
  reg  [2:0] pre;
  wire [13:0] rise = s2 & ~s3; // [RL22]
  wire [13:0] fall = ~s2 & s3;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1  <= 14'h0000;
      s2  <= 14'h0000;
      s3  <= 14'h0000;
      pre <= 3'h0;
    end else begin
      s1  <= {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a,
              capture_compare_pin_b_in, capture_compare_pin_a_in}; // [RL18]
      s2  <= s1;
      s3  <= s2;
      pre <= pre + 3'h1;
    end
  end

  wire [7:0] tick_src = {rise[13:10], (pre == 3'h7), (pre[1:0] == 2'h3), pre[0], 1'b1}; // [RL2]

  // ==========================================================================
  // Channels
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg  [4:0] ctl;
      reg  [5:0] io;
      reg [15:0] cnt; // [RL1]
      reg [15:0] gra;
      reg [15:0] grb;
      reg [15:0] bra;
      reg [15:0] brb;
      reg  [2:0] flg;
      reg        pa;
      reg        pb;
      reg        down;
      wire       phase = (g == 2) && mode[`FTPU_MODE_PHASE];
      wire       cmpl  = (g == 3) && cpwm;
      wire       bufm  = (g == 3) ? mode[`FTPU_MODE_BUF3] : ((g == 4) && mode[`FTPU_MODE_BUF4]);
      wire       qstep = (s2[10] ^ s3[10]) | (s2[11] ^ s3[11]);         // [RL19]
      wire       qup   = s2[10] ^ s3[11];                                // [RL10]
      wire       tick  = start[g] & (phase ? qstep : tick_src[ctl[2:0]]);
      wire       up    = phase ? qup : ~(cmpl & down);
      wire       cap_a = cap_hit(io[2:0], rise[g], fall[g]);
      wire       cap_b = cap_hit(io[5:3], rise[g + 5], fall[g + 5]);
      wire       m_a   = tick & ~io[2] & (cnt == gra);
      wire       m_b   = tick & ~io[5] & (cnt == grb);
      wire       e_a   = m_a | cap_a;
      wire       e_b   = m_b | cap_b;
      wire [1:0] csel  = ((g == 3) && rspwm) ? `FTPU_CLR_A : ctl[4:3];
      wire       own   = ((csel == `FTPU_CLR_A) & e_a) | ((csel == `FTPU_CLR_B) & e_b); // [RL6]
      wire       clr   = own | ((csel == `FTPU_CLR_SYNC) & sync[g] & sync_clr);         // [RL8]
      wire       ovf   = tick & ~clr & (up ? (cnt == `FTPU_CNT_MAX) : (cnt == 16'h0000)); // [RL21]
      wire       rebuf = bufm & (clr | ovf | (cmpl & tick & down & (cnt == 16'h0001)));
      wire [2:0] st_w  = (wr && (paddr == `FTPU_OFF_STATUS)) ? pwdata[3 * g +: 3] : 3'h0;
      wire       wsel  = wr && in_ch && (chidx == g);

      assign cnt_f[16 * g +: 16] = cnt;
      assign gra_f[16 * g +: 16] = gra;
      assign grb_f[16 * g +: 16] = grb;
      assign bra_f[16 * g +: 16] = bra;
      assign brb_f[16 * g +: 16] = brb;
      assign ctl_f[5 * g +: 5]   = ctl;
      assign io_f[6 * g +: 6]    = io;
      assign flags[3 * g +: 3]   = flg;
      assign clr_req[g]          = own;
      assign pin_a[g]            = pa;
      assign pin_b[g]            = pb;
      assign oe_a[g]             = mode[g] | (~io[2] & (io[1:0] != 2'h0));
      assign oe_b[g]             = ~mode[g] & ~io[5] & (io[4:3] != 2'h0);
      assign ev_a[g]             = e_a;
      assign ev_b[g]             = e_b;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl  <= 5'h00;
          io   <= 6'h00;
          cnt  <= `FTPU_CNT_RESET;
          gra  <= `FTPU_GR_RESET;
          grb  <= `FTPU_GR_RESET;
          bra  <= `FTPU_GR_RESET;
          brb  <= `FTPU_GR_RESET;
          flg  <= 3'h0;
          pa   <= 1'b0;
          pb   <= 1'b0;
          down <= 1'b0;
        end else begin
          if (wsel && (sub == `FTPU_SUB_CTRL))
            ctl <= pwdata[4:0];
          if (wsel && (sub == `FTPU_SUB_IOCTL))
            io <= pwdata[5:0];
          if (cnt_wr_ch[g] || (sync[g] && sync_load)) begin // [RL7]
            cnt <= pwdata[15:0];                            // [RL14]
          end else if (clr) begin
            cnt <= 16'h0000;
          end else if (tick) begin
            cnt <= up ? cnt + 16'h0001 : cnt - 16'h0001;
          end
          if (cmpl && tick) begin
            if (!down && (cnt == gra))
              down <= 1'b1;
            else if (down && (cnt == 16'h0001))
              down <= 1'b0;
          end else if (!cmpl) begin
            down <= 1'b0;
          end
          if (wsel && (sub == `FTPU_SUB_GRA))
            gra <= pwdata[15:0];
          if (wsel && (sub == `FTPU_SUB_GRB))
            grb <= pwdata[15:0];
          if (wsel && (sub == `FTPU_SUB_BRA))
            bra <= pwdata[15:0];
          if (wsel && (sub == `FTPU_SUB_BRB))
            brb <= pwdata[15:0];
          // Buffered capture keeps the previous value in the buffer register.
          if (cap_a) begin
            gra <= cnt; // [RL3]
            if (bufm)
              bra <= gra; // [RL13]
          end else if (rebuf && !io[2]) begin
            gra <= bra; // [RL13]
          end
          if (cap_b) begin
            grb <= cnt;
            if (bufm)
              brb <= grb;
          end else if (rebuf && !io[5]) begin
            grb <= brb;
          end
          flg <= (flg & ~st_w) | {ovf, e_b, e_a}; // [RL15]
          if (mode[g]) begin
            if (m_a)
              pa <= 1'b1; // [RL9]
            else if (m_b)
              pa <= 1'b0;
          end else begin
            if (m_a)
              pa <= pin_next(io[2:0], pa, g != 2);
            if (m_b)
              pb <= pin_next(io[5:3], pb, g != 2);
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Three-phase PWM from channel 3 counter against three duty registers
  wire [15:0] c3   = cnt_f[63:48];
  wire  [2:0] praw = {c3 < grb_f[79:64], c3 < gra_f[79:64], c3 < grb_f[63:48]};
  reg   [2:0] pdly;
  wire  [2:0] ppos = cpwm ? (praw & pdly) : praw;     // [RL12]
  wire  [2:0] pneg = cpwm ? (~praw & ~pdly) : ~praw;  // [RL11]
  wire        three = rspwm | cpwm;

  // ==========================================================================
  // Registered outputs and shared registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start                     <= 5'h00;
      sync                      <= 5'h00;
      mode                      <= 10'h000;
      ien                       <= 15'h0000;
      pdly                      <= 3'h0;
      capture_compare_pin_a_out <= 5'h00;
      capture_compare_pin_a_oe  <= 5'h00;
      capture_compare_pin_b_out <= 5'h00;
      capture_compare_pin_b_oe  <= 5'h00;
      extra_pwm_out_a_ch4       <= 1'b0;
      extra_pwm_out_b_ch4       <= 1'b0;
      irq                       <= 15'h0000;
      dma_req                   <= 4'h0;
      tpc_trig                  <= 4'h0;
    end else begin
      if (wr_com && (paddr == `FTPU_OFF_START))
        start <= pwdata[4:0];
      if (wr_com && (paddr == `FTPU_OFF_SYNC))
        sync <= pwdata[4:0];
      if (wr_com && (paddr == `FTPU_OFF_MODE))
        mode <= pwdata[9:0];
      if (wr_com && (paddr == `FTPU_OFF_IEN))
        ien <= pwdata[14:0];
      pdly <= praw;
      capture_compare_pin_a_out <= three ? {ppos[1], pneg[2], pin_a[2:0]} : pin_a;
      capture_compare_pin_a_oe  <= three ? {2'h3, oe_a[2:0]} : oe_a;
      capture_compare_pin_b_out <= three ? {ppos[2], ppos[0], pin_b[2:0]} : pin_b;
      capture_compare_pin_b_oe  <= three ? {2'h3, oe_b[2:0]} : oe_b;
      extra_pwm_out_a_ch4       <= three & pneg[0]; // [RL20]
      extra_pwm_out_b_ch4       <= three & pneg[1];
      irq                       <= flags & ien;     // [RL15]
      dma_req                   <= ev_a[3:0];       // [RL16]
      tpc_trig                  <= ev_a[3:0] | ev_b[3:0]; // [RL17]
    end
  end

  // ==========================================================================
  // Read path
  reg [31:0] rd;
  reg        bad;
  always @* begin
    rd  = 32'h00000000;
    bad = 1'b0;
    if (in_ch) begin
      case (sub)
        `FTPU_SUB_CTRL:  rd[4:0]  = ctl_f[5 * chidx +: 5];
        `FTPU_SUB_IOCTL: rd[5:0]  = io_f[6 * chidx +: 6];
        `FTPU_SUB_CNT:   rd[15:0] = cnt_f[16 * chidx +: 16];
        `FTPU_SUB_GRA:   rd[15:0] = gra_f[16 * chidx +: 16];
        `FTPU_SUB_GRB:   rd[15:0] = grb_f[16 * chidx +: 16];
        `FTPU_SUB_BRA:   rd[15:0] = bra_f[16 * chidx +: 16];
        `FTPU_SUB_BRB:   rd[15:0] = brb_f[16 * chidx +: 16];
        default:         bad      = 1'b1;
      endcase
    end else begin
      case (paddr)
        `FTPU_OFF_START:  rd[4:0]  = start;
        `FTPU_OFF_SYNC:   rd[4:0]  = sync;
        `FTPU_OFF_MODE:   rd[9:0]  = mode;
        `FTPU_OFF_STATUS: rd[14:0] = flags;
        `FTPU_OFF_IEN:    rd[14:0] = ien;
        default:          bad      = 1'b1;
      endcase
    end
    if (paddr[1:0] != 2'h0)
      bad = 1'b1;
  end

  // Answer is prepared in setup so that pready and prdata leave flip-flops.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & bad;
      if (setup)
        prdata <= (pwrite | bad) ? 32'h00000000 : rd;
    end
  end

endmodule // ftpu_timer_pulse_unit

// *** sim/ftpu_chk_sva.sv ***
// Port-level checks of the timer pulse unit: APB answer timing and event outputs.
// Assumes the unit's top-level port names; attached by the bind at the foot.
`timescale 1ns/100ps

// ==========================================================================
// Checker
module ftpu_chk #(
  parameter NCH = 5
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [14:0] irq,
  input wire [3:0]  dma_req,
  input wire [3:0]  tpc_trig
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_only: assert property (!(psel && !penable) |=> !pready)
    else $error("pready outside first access cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_bad_read: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read gave data");
  chk_upper_zero: assert property (pready && !pwrite && paddr[7:6] != 2'h0 |-> prdata[31:16] == 16'h0)
    else $error("channel register upper half nonzero");
  chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  chk_dma_trig: assert property (dma_req != 4'h0 |-> (tpc_trig & dma_req) == dma_req)
    else $error("register A event without pattern trigger");
  chk_reset_quiet: assert property ($rose(presetn) |-> irq == 15'h0 && dma_req == 4'h0 && !pready)
    else $error("outputs active at first edge after reset");
endmodule // ftpu_chk

bind ftpu_timer_pulse_unit ftpu_chk #(.NCH(NCH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .dma_req(dma_req), .tpc_trig(tpc_trig)
);

// *** sim/ftpu_pin_model.sv ***
// Pin-side model of the timer pulse unit: external clocks, encoder pair, capture inputs.
// Assumes the bench calls its tasks just after a pclk edge.
`timescale 1ns/100ps

// ==========================================================================
// Pin model
module ftpu_pin_model (
  input  wire       pclk,
  input  wire [4:0] a_out,
  input  wire [4:0] a_oe,
  input  wire [4:0] b_out,
  input  wire [4:0] b_oe,
  output reg  [3:0] ext_ck,
  output wire [4:0] a_in,
  output wire [4:0] b_in
);
  reg [4:0] drv_a = 5'h00;
  reg [1:0] ph    = 2'h0;

  initial ext_ck = 4'h0;
  // A pin the unit drives reads back its own level; a free B pin floats, shown as the inverse.
  assign a_in = (a_oe & a_out) | (~a_oe & drv_a);
  assign b_in = (b_oe & b_out) | (~b_oe & ~b_out);

  // Each level stands four cycles so the two-flop synchronizer sees every edge once.
  task automatic hold;
    repeat (4) @(posedge pclk);
  endtask
  task automatic pulse_c(input int n);
    repeat (n) begin
      ext_ck[2] <= 1'b1;
      hold;
      ext_ck[2] <= 1'b0;
      hold;
    end
  endtask
  task automatic set_a(input int ch, input bit v);
    drv_a[ch] <= v;
    hold;
  endtask
  // Forward steps run 00, 10, 11, 01 on phases A and B, so A leads B.
  task automatic enc(input bit fwd, input int n);
    repeat (n) begin
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      ext_ck[1:0] <= {ph[1], ph[1] ^ ph[0]};
      hold;
    end
  endtask
endmodule // ftpu_pin_model

// *** sim/ftpu_timer_pulse_unit_tb.sv ***
// Bench for the timer pulse unit: APB register tasks, pin model, checked scenarios.
// Assumes the unit, its constant header, the pin model and the bound checker.
`timescale 1ns/100ps
`include "ftpu_defines.vh"

// ==========================================================================
// Bench
module ftpu_timer_pulse_unit_tb;
  reg          pclk        = 1'b0;
  reg          presetn     = 1'b0;
  reg          psel        = 1'b0;
  reg          penable     = 1'b0;
  reg          pwrite      = 1'b0;
  reg  [7:0]   paddr       = 8'h00;
  reg  [31:0]  pwdata      = 32'h0;
  reg          dma_seen    = 1'b0;
  wire [31:0]  prdata;
  wire         pready;
  wire         pslverr;
  wire [3:0]   ext_ck;
  wire [4:0]   a_in, b_in, a_out, a_oe, b_out, b_oe;
  wire [14:0]  irq;
  wire [3:0]   dma_req;
  wire [3:0]   tpc_trig;
  wire         xa;
  wire         xb;
  logic [31:0] q;
  logic        e;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          n;
  int          cnt;
  int          exp_v;

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (dma_req[0] === 1'b1) dma_seen <= 1'b1;
  end

  ftpu_timer_pulse_unit #(.NCH(5)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_in_a(ext_ck[0]), .ext_clock_in_b(ext_ck[1]), .ext_clock_in_c(ext_ck[2]), .ext_clock_in_d(ext_ck[3]),
    .capture_compare_pin_a_in(a_in), .capture_compare_pin_b_in(b_in),
    .capture_compare_pin_a_out(a_out), .capture_compare_pin_a_oe(a_oe),
    .capture_compare_pin_b_out(b_out), .capture_compare_pin_b_oe(b_oe),
    .extra_pwm_out_a_ch4(xa), .extra_pwm_out_b_ch4(xb), .irq(irq), .dma_req(dma_req), .tpc_trig(tpc_trig)
  );
  ftpu_pin_model u_pins (
    .pclk(pclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .ext_ck(ext_ck), .a_in(a_in), .b_in(b_in)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // The request stands until pready is sampled high; a slave that never answers ends the run.
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      error_cnt++;
      wrap_up;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(q, x);
  endtask
  task automatic wait_irq(input int i);
    int k;
    k = 0;
    while (irq[i] !== 1'b1 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    if (k == 500) begin
      error_cnt++;
      wrap_up;
    end
  endtask
  function automatic logic [7:0] ca(input int ch, input logic [2:0] sub);
    ca = {3'(`FTPU_CH_FIRST + ch), sub, 2'b00};
  endfunction

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(ca(0, `FTPU_SUB_CNT), `FTPU_CNT_RESET);
    rd(ca(4, `FTPU_SUB_GRB), `FTPU_GR_RESET);
    rd(ca(3, `FTPU_SUB_BRA), `FTPU_GR_RESET);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, e}, 32'h1);
    wr(`FTPU_OFF_SYNC, 32'h3);
    wr(ca(0, `FTPU_SUB_CNT), 32'h1234);
    rd(ca(1, `FTPU_SUB_CNT), 32'h1234);
    wr(`FTPU_OFF_SYNC, 32'h0);
    wr(ca(0, `FTPU_SUB_CNT), 32'h0);
    wr(ca(0, `FTPU_SUB_GRA), 32'h5);
    wr(ca(0, `FTPU_SUB_CTRL), {27'h0, `FTPU_CLR_A, 3'h0});
    wr(ca(0, `FTPU_SUB_IOCTL), 32'h2);
    wr(`FTPU_OFF_IEN, 32'h1);
    wr(`FTPU_OFF_START, 32'h1);
    wait_irq(0);
    check({30'h0, a_oe[0], a_out[0]}, 32'h3);
    check({31'h0, dma_seen}, 32'h1);
    wr(`FTPU_OFF_START, 32'h0);
    apb(1'b0, ca(0, `FTPU_SUB_CNT), 32'h0);
    check({31'h0, q <= 32'h5}, 32'h1);
    wr(`FTPU_OFF_STATUS, 32'h1);
    rd(`FTPU_OFF_STATUS, 32'h0);
    // Period of seven ticks, high from match A at 2 to match B at 6: ten periods give 40 high cycles.
    wr(`FTPU_OFF_MODE, 32'h1);
    wr(ca(0, `FTPU_SUB_GRA), 32'h2);
    wr(ca(0, `FTPU_SUB_GRB), 32'h6);
    wr(ca(0, `FTPU_SUB_CTRL), {27'h0, `FTPU_CLR_B, 3'h0});
    wr(`FTPU_OFF_START, 32'h1);
    repeat (20) @(posedge pclk);
    n = 0;
    repeat (70) begin
      @(posedge pclk);
      n += (a_out[0] === 1'b1);
    end
    check(32'(n), 32'd40);
    wr(`FTPU_OFF_START, 32'h0);
    wr(`FTPU_OFF_MODE, 32'h0);
    wr(ca(1, `FTPU_SUB_CNT), 32'h0);
    wr(ca(1, `FTPU_SUB_CTRL), 32'h6);
    wr(`FTPU_OFF_START, 32'h2);
    cnt = 0;
    for (int k = 0; k < 3; k++) begin
      wr(ca(1, `FTPU_SUB_IOCTL), 32'(4 + k));
      u_pins.pulse_c(2);
      cnt += 2;
      u_pins.set_a(1, 1'b1);
      exp_v = cnt;
      u_pins.pulse_c(1);
      cnt += 1;
      u_pins.set_a(1, 1'b0);
      if (k != 0) exp_v = cnt;
      rd(ca(1, `FTPU_SUB_GRA), 32'(exp_v));
    end
    wr(`FTPU_OFF_START, 32'h0);
    wr(`FTPU_OFF_MODE, 32'h20);
    wr(ca(2, `FTPU_SUB_CNT), 32'h0);
    wr(`FTPU_OFF_START, 32'h4);
    u_pins.enc(1'b1, 8);
    rd(ca(2, `FTPU_SUB_CNT), 32'h8);
    u_pins.enc(1'b0, 8);
    rd(ca(2, `FTPU_SUB_CNT), 32'h0);
    wr(`FTPU_OFF_START, 32'h0);
    wr(`FTPU_OFF_MODE, 32'h0);
    wr(`FTPU_OFF_STATUS, 32'h7FFF);
    wr(ca(3, `FTPU_SUB_CNT), 32'hFFFD);
    wr(`FTPU_OFF_IEN, 32'h800);
    wr(`FTPU_OFF_START, 32'h8);
    wait_irq(11);
    check({17'h0, irq}, 32'h800);
    wr(`FTPU_OFF_START, 32'h0);
    rd(`FTPU_OFF_STATUS, 32'hE00);
    check({30'h0, xa, xb}, 32'h0);
    wrap_up;
  end
endmodule // ftpu_timer_pulse_unit_tb
